/* src/fvt_pkg.sv */
package fvt_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ            = 125;
  localparam int MIN_TURNON_NS      = 197;
  localparam int MIN_TURNON_CYC     = (MIN_TURNON_NS * CLK_MHZ + 999) / 1000;
  localparam int OVERLOAD_MS        = 50;
  localparam int OVERLOAD_CYC       = OVERLOAD_MS * CLK_MHZ * 1000;
  localparam int CLAMP_US           = 100;
  localparam int CLAMP_CYC          = CLAMP_US * CLK_MHZ;
  localparam int RESTART_MS         = 1000;
  localparam int RESTART_CYC        = RESTART_MS * CLK_MHZ * 1000;
  localparam int THERMAL_REST_MS    = 2000;
  localparam int THERMAL_REST_CYC   = THERMAL_REST_MS * CLK_MHZ * 1000;
  localparam int SOFTSTART_US       = 5000;
  localparam int SOFTSTART_CYC      = SOFTSTART_US * CLK_MHZ;
  localparam int OVP_TRIP_COUNT     = 4;
  localparam int OCP_TRIP_COUNT     = 2;
  localparam int DELAY_CODE_W       = 4;
  localparam int DELAY_STEP_CYC     = 4;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    FVT_PWRUP    = 3'h0,
    FVT_RUN      = 3'h1,
    FVT_SOFT     = 3'h2,
    FVT_WAIT     = 3'h3,
    FVT_RECHARGE = 3'h4
  } fvt_mode_t;

  typedef struct packed {
    logic demag_trigger;
    logic demag_end;
    logic osc_tick;
    logic fb_above_sat;
    logic ocp_at_leb_end;
    logic clamp_over_limit;
    logic tb_below_disable;
    logic supply_at_on;
  } fvt_sense_t;

  typedef struct packed {
    logic switch_enable;
    logic turn_on;
    logic hv_source_on;
    logic test_current_on;
    logic blank_enable;
    logic valley_enable;
    logic soft_start;
  } fvt_ctrl_t;

endpackage

/* src/fvt_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module fvt_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fvt_sync_st_t;
  initial begin
    if (W < 1) begin
      $error("fvt_sync: width must be at least one");
    end
  end
  fvt_sync_st_t st_r;
  fvt_sync_st_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule
`default_nettype wire

/* src/fvt_delay_map.sv */
`timescale 1ns/100ps
`default_nettype none
module fvt_delay_map #(
  parameter int CW = fvt_pkg::DELAY_CODE_W
) (
  input  wire logic [CW-1:0] code,
  output var  logic [15:0]   cycles
);
  initial begin
    if (CW < 1 || CW > 13) begin
      $error("fvt_delay_map: code width out of range");
    end
  end

  // monotonic: each code step adds a fixed increment; only code zero gives
  // the minimum delay
  always_comb begin
    cycles = 16'(fvt_pkg::MIN_TURNON_CYC) + 16'(code) * 16'(fvt_pkg::DELAY_STEP_CYC);
  end
endmodule
`default_nettype wire

/* src/fvt_supervisor.sv */
`timescale 1ns/100ps
`default_nettype none

module fvt_supervisor #(
  parameter int OVERLOAD_CYC     = fvt_pkg::OVERLOAD_CYC,
  parameter int RESTART_CYC      = fvt_pkg::RESTART_CYC,
  parameter int THERMAL_REST_CYC = fvt_pkg::THERMAL_REST_CYC,
  parameter int CLAMP_CYC        = fvt_pkg::CLAMP_CYC,
  parameter int SOFTSTART_CYC    = fvt_pkg::SOFTSTART_CYC
) (
  input  wire logic                                clk,
  input  wire logic                                srst,
  input  wire logic                                ce,
  input  wire fvt_pkg::fvt_sense_t                 sense,
  input  wire logic                                demag_ovp_cmp,
  input  wire logic                                valley_req,
  input  wire logic                                blank_req,
  input  wire logic [fvt_pkg::DELAY_CODE_W-1:0]    delay_code,
  output var  fvt_pkg::fvt_ctrl_t                  ctrl,
  output var  logic                                fault_overload,
  output var  logic                                fault_ovp
);

  // ****************************************
  // parameter checks
  // ****************************************
  initial begin
    if (OVERLOAD_CYC < 2 || RESTART_CYC < 1 || THERMAL_REST_CYC < 1 ||
        CLAMP_CYC < 1 || SOFTSTART_CYC < 1 ||
        OVERLOAD_CYC >= 2**30 || THERMAL_REST_CYC >= 2**30) begin
      $error("fvt_supervisor: bad timing parameter");
    end
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  fvt_pkg::fvt_sense_t s;
  logic                ovp_cmp_s;

  fvt_sync #(.W($bits(fvt_pkg::fvt_sense_t) + 1)) u_sync (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .d    ({sense, demag_ovp_cmp}),
    .q    ({s, ovp_cmp_s})
  );

  logic [15:0] delay_cyc;
  fvt_delay_map u_map (
    .code   (delay_code),
    .cycles (delay_cyc)
  );

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    fvt_pkg::fvt_mode_t mode;
    logic [31:0]        olp_cnt;
    logic [31:0]        wait_cnt;
    logic [23:0]        clamp_cnt;
    logic [2:0]         ovp_cnt;
    logic               ovp_seen;
    logic [1:0]         ocp_cnt;
    logic               tb_grounded;
    logic               delay_run;
    logic [15:0]        delay_cnt;
    logic               ovp_flag;
    logic               trip_olp;
    logic               trip_ovp;
    fvt_pkg::fvt_ctrl_t ctrl;
  } fvt_state_t;

  fvt_state_t st_r;
  fvt_state_t st_nxt;
  logic       trig_d_r;
  logic       trig_edge;

  always_ff @(posedge clk) begin
    if (srst) begin
      trig_d_r <= 1'b0;
    end else if (ce) begin
      trig_d_r <= s.demag_trigger;
    end
  end
  assign trig_edge = s.demag_trigger && !trig_d_r;

  always_comb begin
    logic fault;
    logic [31:0] wait_len;
    fault    = 1'b0;
    wait_len = 32'(RESTART_CYC);
    st_nxt   = st_r;
    st_nxt.ctrl.turn_on = 1'b0;

    // ****************************************
    // output overvoltage sampling
    // ****************************************
    if (s.demag_end && ovp_cmp_s) begin
      st_nxt.ovp_seen = 1'b1;
    end
    st_nxt.ovp_flag = st_r.ovp_seen;
    if (s.osc_tick) begin
      if (st_r.ovp_seen || (s.demag_end && ovp_cmp_s)) begin
        if (st_r.ovp_cnt < 3'(fvt_pkg::OVP_TRIP_COUNT)) begin
          st_nxt.ovp_cnt = st_r.ovp_cnt + 3'h1;
        end
      end else begin
        st_nxt.ovp_cnt = 3'h0;
      end
      st_nxt.ovp_seen = 1'b0;
    end

    // ****************************************
    // post-blanking overcurrent, supply clamp
    // ****************************************
    if (s.osc_tick) begin
      if (s.ocp_at_leb_end) begin
        st_nxt.ocp_cnt = (st_r.ocp_cnt == 2'h3) ? 2'h3 : st_r.ocp_cnt + 2'h1;
      end else begin
        st_nxt.ocp_cnt = 2'h0;
      end
    end
    if (s.clamp_over_limit) begin
      if (st_r.clamp_cnt < 24'(CLAMP_CYC)) begin
        st_nxt.clamp_cnt = st_r.clamp_cnt + 24'h1;
      end
    end else begin
      st_nxt.clamp_cnt = 24'h0;
    end

    // ****************************************
    // overload counter, cleared in soft-start, frozen in the other modes outside normal run
    // ****************************************
    if (st_r.mode == fvt_pkg::FVT_RUN) begin
      if (s.fb_above_sat) begin
        st_nxt.olp_cnt = st_r.olp_cnt + 32'h1;
      end else if (st_r.olp_cnt != 32'h0) begin
        st_nxt.olp_cnt = st_r.olp_cnt - 32'h1;
      end
    end else if (st_r.mode == fvt_pkg::FVT_SOFT) begin
      st_nxt.olp_cnt = 32'h0;
    end

    // ****************************************
    // mode sequencing
    // ****************************************
    case (st_r.mode)
      fvt_pkg::FVT_PWRUP: begin
        st_nxt.ctrl.test_current_on = 1'b1;
        st_nxt.ctrl.hv_source_on    = 1'b1;
        if (s.supply_at_on) begin
          st_nxt.tb_grounded          = s.tb_below_disable;
          st_nxt.ctrl.test_current_on = 1'b0;
          st_nxt.ctrl.hv_source_on    = 1'b0;
          st_nxt.ctrl.switch_enable   = 1'b1;
          st_nxt.ctrl.soft_start      = 1'b1;
          st_nxt.wait_cnt             = 32'h0;
          st_nxt.mode                 = fvt_pkg::FVT_SOFT;
        end
      end
      fvt_pkg::FVT_RUN, fvt_pkg::FVT_SOFT: begin
        if (st_r.olp_cnt >= 32'(OVERLOAD_CYC)) begin
          fault           = 1'b1;
          st_nxt.trip_olp = 1'b1;
        end
        if (st_r.ovp_cnt >= 3'(fvt_pkg::OVP_TRIP_COUNT)) begin
          fault           = 1'b1;
          st_nxt.trip_ovp = 1'b1;
        end
        if (st_r.clamp_cnt >= 24'(CLAMP_CYC)) begin
          fault = 1'b1;
        end
        if (st_r.ocp_cnt >= 2'(fvt_pkg::OCP_TRIP_COUNT)) begin
          fault    = 1'b1;
          wait_len = 32'(THERMAL_REST_CYC);
        end
        if (st_r.mode == fvt_pkg::FVT_SOFT) begin
          st_nxt.wait_cnt = st_r.wait_cnt + 32'h1;
          if (st_r.wait_cnt >= 32'(SOFTSTART_CYC)) begin
            st_nxt.ctrl.soft_start = 1'b0;
            st_nxt.mode            = fvt_pkg::FVT_RUN;
            st_nxt.trip_olp        = 1'b0;
            st_nxt.trip_ovp        = 1'b0;
          end
        end
        if (fault) begin
          st_nxt.ctrl.switch_enable = 1'b0;
          st_nxt.ctrl.soft_start    = 1'b0;
          st_nxt.delay_run          = 1'b0;
          st_nxt.olp_cnt            = 32'h0;
          st_nxt.ovp_cnt            = 3'h0;
          st_nxt.ocp_cnt            = 2'h0;
          st_nxt.clamp_cnt          = 24'h0;
          st_nxt.wait_cnt           = wait_len;
          st_nxt.mode               = fvt_pkg::FVT_WAIT;
        end
      end
      fvt_pkg::FVT_WAIT: begin
        // supply recycling: hv source toggled by supply comparator
        st_nxt.ctrl.hv_source_on = !s.supply_at_on;
        if (st_r.wait_cnt != 32'h0) begin
          st_nxt.wait_cnt = st_r.wait_cnt - 32'h1;
        end else begin
          st_nxt.mode = fvt_pkg::FVT_RECHARGE;
        end
      end
      fvt_pkg::FVT_RECHARGE: begin
        st_nxt.ctrl.hv_source_on = 1'b1;
        if (s.supply_at_on && st_r.ctrl.hv_source_on) begin
          st_nxt.ctrl.hv_source_on  = 1'b0;
          st_nxt.ctrl.switch_enable = 1'b1;
          st_nxt.ctrl.soft_start    = 1'b1;
          st_nxt.wait_cnt           = 32'h0;
          st_nxt.mode               = fvt_pkg::FVT_SOFT;
        end
      end
      default: begin
        st_nxt.mode = fvt_pkg::FVT_PWRUP;
      end
    endcase

    // ****************************************
    // turn-on delay after demag trigger
    // ****************************************
    st_nxt.ctrl.blank_enable  = blank_req && !st_nxt.tb_grounded;
    st_nxt.ctrl.valley_enable = valley_req && !st_nxt.tb_grounded;
    if (trig_edge && st_r.ctrl.switch_enable && !fault) begin
      st_nxt.delay_run = 1'b1;
      st_nxt.delay_cnt = st_r.ctrl.valley_enable ? delay_cyc
                                                : 16'(fvt_pkg::MIN_TURNON_CYC);
    end else if (st_r.delay_run) begin
      if (st_r.delay_cnt <= 16'h1) begin
        st_nxt.delay_run    = 1'b0;
        // a tripping fault wins over a pending turn-on
        st_nxt.ctrl.turn_on = st_r.ctrl.switch_enable && !fault;
      end else begin
        st_nxt.delay_cnt = st_r.delay_cnt - 16'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign ctrl           = st_r.ctrl;
  assign fault_overload = st_r.trip_olp;
  assign fault_ovp      = st_r.trip_ovp;

  // ****************************************
  // checks
  // ****************************************
  sequence s_delay_armed;
    !st_r.delay_run ##1 st_r.delay_run;
  endsequence

  chk_min_delay: assert property (@(posedge clk) disable iff (srst || !ce)
    s_delay_armed |-> !st_r.ctrl.turn_on [*8])
    else $error("turn-on too early");
  chk_ovp_reset: assert property (@(posedge clk) disable iff (srst)
    (ce && s.osc_tick && !st_r.ovp_seen && !(s.demag_end && ovp_cmp_s)
     && st_r.mode != fvt_pkg::FVT_PWRUP) |=> st_r.ovp_cnt == 3'h0)
    else $error("ovp counter not cleared");
  chk_ovp_trip: assert property (@(posedge clk) disable iff (srst)
    (ce && st_r.ovp_cnt == 3'h4 && st_r.mode == fvt_pkg::FVT_RUN) |=> !st_r.ctrl.switch_enable)
    else $error("ovp did not stop switching");
  chk_olp_soft: assert property (@(posedge clk) disable iff (srst)
    (ce && st_r.mode == fvt_pkg::FVT_SOFT) |=> st_r.olp_cnt == 32'h0)
    else $error("overload counter active in soft-start");
  chk_olp_count: assert property (@(posedge clk) disable iff (srst)
    (ce && st_r.mode == fvt_pkg::FVT_RUN && s.fb_above_sat && st_nxt.mode == fvt_pkg::FVT_RUN)
    |=> st_r.olp_cnt == $past(st_r.olp_cnt) + 32'h1)
    else $error("overload counter did not count up");
  chk_olp_trip: assert property (@(posedge clk) disable iff (srst)
    (ce && st_r.mode == fvt_pkg::FVT_RUN && st_r.olp_cnt >= 32'(OVERLOAD_CYC))
    |=> st_r.mode == fvt_pkg::FVT_WAIT && !st_r.ctrl.switch_enable)
    else $error("overload did not trip");
  chk_ocp_trip: assert property (@(posedge clk) disable iff (srst)
    (ce && st_r.mode == fvt_pkg::FVT_RUN && st_r.ocp_cnt == 2'h2) |=> st_r.mode == fvt_pkg::FVT_WAIT)
    else $error("overcurrent did not trip");
  chk_wait_noswitch: assert property (@(posedge clk) disable iff (srst)
    st_r.mode == fvt_pkg::FVT_WAIT |-> !st_r.ctrl.switch_enable && !st_r.ctrl.turn_on)
    else $error("switching during restart wait");
  chk_gnd_latch: assert property (@(posedge clk) disable iff (srst)
    (ce && st_r.mode != fvt_pkg::FVT_PWRUP) |=> st_r.tb_grounded == $past(st_r.tb_grounded))
    else $error("pin ground decision changed");
  chk_test_cur: assert property (@(posedge clk) disable iff (srst)
    (st_r.ctrl.test_current_on) |-> st_r.mode == fvt_pkg::FVT_PWRUP)
    else $error("test current outside power-up");
endmodule
`default_nettype wire

/* tb/fvt_far_side.sv */
`timescale 1ns/100ps
`default_nettype none
module fvt_far_side #(
  parameter int PERIOD = 128,
  parameter int CHARGE = 20
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic hv_source_on,
  input  wire logic switch_enable,
  output var  logic demag_trigger,
  output var  logic demag_end,
  output var  logic osc_tick,
  output var  logic supply_at_on
);
  int phase = 0;
  int lvl   = 0;
  initial begin
    demag_trigger = 1'b0;
    demag_end     = 1'b0;
    osc_tick      = 1'b0;
    supply_at_on  = 1'b0;
  end
  // ****************************************
  // winding events, one clock wide
  // ****************************************
  // no demag edges while the switch is idle; the oscillator runs free
  always @(negedge clk) begin
    phase = (phase + 1) % PERIOD;
    demag_trigger <= switch_enable && (phase == 0);
    demag_end     <= switch_enable && (phase == 100);
    osc_tick      <= (phase == 120);
  end
  // ****************************************
  // supply capacitor
  // ****************************************
  // sags only when neither switching nor hv source feeds it; hysteresis
  always @(negedge clk) begin
    if (srst) begin
      lvl = 0;
    end else if (hv_source_on) begin
      lvl = (lvl < CHARGE) ? lvl + 1 : CHARGE;
    end else if (!switch_enable && lvl > 0) begin
      lvl = lvl - 1;
    end
    if (srst || lvl == 0) begin
      supply_at_on <= 1'b0;
    end else if (lvl == CHARGE) begin
      supply_at_on <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int OVL = 20;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic fb = 1'b0, ocp = 1'b0, clp = 1'b0, tbg = 1'b0, cmp = 1'b0;
  logic vreq = 1'b0, breq = 1'b0;
  logic [3:0] code = 4'h0;
  logic trig, dend, tick, son, f_ol, f_ov;
  fvt_pkg::fvt_sense_t sense;
  fvt_pkg::fvt_ctrl_t  ctrl;
  int err_count = 0;
  int comparisons = 0;
  logic [31:0] vq[$];
  logic [31:0] vobs;
  event v_ev;
  always #4 clk = ~clk;
  assign sense = {trig, dend, tick, fb, ocp, clp, tbg, son};
  // short counts so restarts fit in a few hundred cycles
  fvt_supervisor #(.OVERLOAD_CYC(OVL), .RESTART_CYC(10), .THERMAL_REST_CYC(10),
    .CLAMP_CYC(5), .SOFTSTART_CYC(10)) i_fvt_supervisor (.clk(clk), .srst(srst),
    .ce(ce), .sense(sense), .demag_ovp_cmp(cmp), .valley_req(vreq), .blank_req(breq),
    .delay_code(code), .ctrl(ctrl), .fault_overload(f_ol), .fault_ovp(f_ov));
  fvt_far_side i_fvt_far_side (.clk(clk), .srst(srst), .hv_source_on(ctrl.hv_source_on),
    .switch_enable(ctrl.switch_enable), .demag_trigger(trig), .demag_end(dend),
    .osc_tick(tick), .supply_at_on(son));
  // ****************************************
  // scoreboard
  // ****************************************
  task automatic cmp_val(input logic [31:0] e, input logic [31:0] o);
    comparisons++;
    if (e !== o) begin
      err_count++;
      $display("[ERR] t=%0t exp=%0h got=%0h", $time, e, o);
    end
  endtask
  // the 1 ns gap lets the watcher re-arm before the next note
  task automatic note(input logic [31:0] e, input logic [31:0] o);
    vq.push_back(e);
    vobs = o;
    -> v_ev;
    #1;
  endtask
  initial forever begin
    @(v_ev);
    cmp_val(vq.pop_front(), vobs);
  end
  task automatic wrap_up();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(negedge clk);
    err_count++;
    wrap_up();
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return ctrl.switch_enable;
      1: return ctrl.soft_start;
      2: return f_ov;
      3: return f_ol;
      default: return ctrl.turn_on;
    endcase
  endfunction
  task automatic wait_sig(input int w, input logic lv, input int lim, output int n);
    n = 0;
    while (pick(w) !== lv && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (pick(w) !== lv) n = -1;
  endtask
  task automatic wok(input int w, input logic lv, input int lim);
    int n;
    wait_sig(w, lv, lim, n);
    note(1, n >= 0);
  endtask
  task automatic ticks(input int k);
    repeat (k) @(posedge clk iff tick);
    @(negedge clk);
  endtask
  // second trigger only, so the new code has settled
  task automatic meas(input logic [3:0] c, output int n);
    code = c;
    repeat (2) @(posedge clk iff trig);
    @(negedge clk);
    wait_sig(4, 1'b1, 200, n);
  endtask
  task automatic power_on(input logic g);
    srst = 1'b1;
    tbg = g;
    cyc(12);
    srst = 1'b0;
    cyc(3);
    note(1, {ctrl.test_current_on, ctrl.hv_source_on} == 2'h3);
    wok(1, 1'b1, 200);
    wok(1, 1'b0, 200);
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    int d0, dn, n;
    logic [3:0] c;
    void'($urandom(32'h7DC94DBF));
    power_on(1'b1);
    {vreq, breq} = 2'h3;
    cyc(4);
    note(0, {ctrl.blank_enable, ctrl.valley_enable});
    tbg = 1'b0;
    cyc(8);
    note(0, {ctrl.blank_enable, ctrl.valley_enable});
    $display("grounded pin test done");
    power_on(1'b0);
    for (int i = 0; i < 4; i++) begin
      {vreq, breq} = i[1:0];
      cyc(4);
      note(i, {ctrl.valley_enable, ctrl.blank_enable});
    end
    $display("enable matrix test done");
    vreq = 1'b1;
    meas(4'h0, d0);
    note(1, d0 >= fvt_pkg::MIN_TURNON_CYC);
    for (int i = 0; i < 4; i++) begin
      c = (i == 0) ? 4'hF : 4'($urandom_range(14, 1));
      meas(c, dn);
      note(c * 4, dn - d0);
    end
    vreq = 1'b0;
    meas(4'hF, dn);
    note(d0, dn);
    $display("turn-on delay test done");
    vreq = 1'b1;
    ticks(1);
    cmp = 1'b1;
    ticks(3);
    cmp = 1'b0;
    ticks(1);
    cmp = 1'b1;
    ticks(3);
    note(0, f_ov);
    ticks(1);
    cyc(6);
    note(2, {f_ov, ctrl.switch_enable});
    wok(1, 1'b1, 1000);
    wok(1, 1'b0, 100);
    cyc(3);
    note(0, f_ov);
    wok(2, 1'b1, 1000);
    cmp = 1'b0;
    wok(1, 1'b1, 1000);
    wok(1, 1'b0, 100);
    ticks(5);
    note(1, {f_ov, ctrl.switch_enable});
    $display("output overvoltage test done");
    for (int i = 0; i < 2; i++) begin
      fb = 1'b1;
      cyc($urandom_range(15, 12));
      fb = 1'b0;
      cyc(40);
    end
    note(1, {f_ol, ctrl.switch_enable});
    fb = 1'b1;
    wait_sig(3, 1'b1, 100, n);
    note(1, n >= OVL && n <= OVL + 8);
    note(0, ctrl.switch_enable);
    wok(1, 1'b1, 1000);
    wok(1, 1'b0, 100);
    cyc(2);
    note(1, {f_ol, ctrl.switch_enable});
    fb = 1'b0;
    cyc(40);
    $display("overload test done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk iff trig);
      cyc(100);
      // hold across the oscillator tick, where the check is sampled
      ocp = (i != 1);
      cyc(25);
      ocp = 1'b0;
      if (i == 1) note(1, ctrl.switch_enable);
    end
    cyc(6);
    note(0, ctrl.switch_enable);
    wok(1, 1'b1, 1000);
    wok(1, 1'b0, 100);
    $display("overcurrent test done");
    ce = 1'b0;
    clp = 1'b1;
    cyc(20);
    clp = 1'b0;
    ce = 1'b1;
    cyc(4);
    note(1, ctrl.switch_enable);
    clp = 1'b1;
    cyc(3);
    clp = 1'b0;
    cyc(10);
    note(1, ctrl.switch_enable);
    clp = 1'b1;
    cyc(12);
    clp = 1'b0;
    note(0, ctrl.switch_enable);
    wok(1, 1'b1, 1000);
    $display("supply clamp test done");
    wrap_up();
  end
endmodule
`default_nettype wire
